// ==== dv/amf_host.sv ====
// Purpose: host model driving the control register port of the codec block
// Assumes: one-cycle strobes; acknowledge comes exactly one cycle later
// Notes: address and data toggle while idle so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module amf_host (
  input  wire logic       i_ref_clk,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic       o_spi,
  output var  logic [9:0] o_addr,
  output var  logic [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_ack
);
  logic busy = 1'b0;
  initial begin
    o_wr = 1'b0; o_rd = 1'b0; o_spi = 1'b0; o_addr = 10'h155; o_wdata = 8'h5a;
  end
  // idle lines keep changing: the device is not allowed to use them
  always @(posedge i_ref_clk) begin
    if (!busy) begin
      o_addr  <= ~o_addr;
      o_wdata <= ~o_wdata;
    end
  end
  task automatic access(input logic w, input logic s, input logic [9:0] a,
                        input logic [7:0] d, output logic ak, output logic [7:0] q);
    busy = 1'b1;
    @(posedge i_ref_clk);
    o_wr <= w; o_rd <= ~w; o_spi <= s; o_addr <= a; o_wdata <= d;
    @(posedge i_ref_clk);
    o_wr <= 1'b0; o_rd <= 1'b0;
    @(negedge i_ref_clk);
    ak = i_ack;
    q  = i_rdata;
    busy = 1'b0;
  endtask : access
endmodule : amf_host
`default_nettype wire

// ==== dv/audio_mix_filter_gain_pdm_bench.sv ====
// Purpose: self-checking bench of the mix, filter, gain and pdm block
// Assumes: adc left input stays zero until the sidetone scenario drives it
// Notes: settings reach the outputs only after the owning sample tick
`timescale 1ns/10ps
`default_nettype none
module audio_mix_filter_gain_pdm_bench;
  import amf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, t1 = 1'b0, t2 = 1'b0;
  logic signed [15:0] p1l = '0, p2l = '0, zs = '0, adl = '0;
  logic vld_seen;
  wire logic wr, rd, spi, ack, dvld, pclk, fir, adc_dc, dac_dc, st_on, i4x, p2dc, smut, vmut;
  wire logic [9:0] addr;
  wire logic [7:0] wd, rdat;
  wire logic signed [15:0] dac_l, dac_r, sdt;
  wire logic [3:0] slot, slot2;
  wire logic [4:0] frame_sync_width, fsw2;
  wire logic [2:0] adc_iir, dac_iir;
  wire logic [1:0] lroute, pdat;
  wire logic signed [7:0] st_d, st_s, vc, va, sa, adb, rdb, ldb, rldb;
  int fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  amf_host i_host (.i_ref_clk(clk), .o_wr(wr), .o_rd(rd), .o_spi(spi), .o_addr(addr),
    .o_wdata(wd), .i_rdata(rdat), .i_ack(ack));
  amf_core #(.SAMPLE_W(16)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_spi(spi), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_ack(ack), .i_p1_tick(t1), .i_p2_tick(t2),
    .i_p1_left(p1l), .i_p1_right(zs), .i_p2_left(p2l), .i_p2_right(zs),
    .i_adc_left(adl), .i_adc_right(zs), .o_dac_left(dac_l), .o_dac_right(dac_r),
    .o_dac_valid(dvld), .o_sidetone(sdt), .o_pdm_clk(pclk), .o_pdm_data_out(pdat),
    .o_p1_slot_delay(slot), .o_p2_slot_delay(slot2), .o_p1_fs_width(frame_sync_width), .o_p2_fs_width(fsw2),
    .o_interp_4x(i4x), .o_fir_mode(fir), .o_adc_iir_code(adc_iir), .o_dac_iir_code(dac_iir),
    .o_adc_dc_block(adc_dc), .o_dac_dc_block(dac_dc), .o_p2_dc_block(p2dc),
    .o_sidetone_on(st_on), .o_sidetone_db_diff(st_d), .o_sidetone_db_se(st_s),
    .o_stereo_dac_mute(smut), .o_voice_dac_mute(vmut), .o_voice_coarse_db(vc),
    .o_voice_atten_db(va), .o_stereo_atten_db(sa), .o_adc_left_db(adb), .o_adc_right_db(rdb),
    .o_line_in_route(lroute), .o_line_in_left_db(ldb), .o_line_in_right_db(rldb));
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %0d expected %0d", $time, got, exp);
    end
  endtask : chk
  // four-wire form sits at base plus offset
  task automatic reg_wr(input logic s, input logic [7:0] ofs, input logic [7:0] d);
    logic ak;
    logic [7:0] q;
    i_host.access(1'b1, s, s ? AMF_SPI_BASE + {2'b00, ofs} : {2'b00, ofs}, d, ak, q);
    chk(ak, 1);
  endtask : reg_wr
  task automatic reg_rd(input logic s, input logic [9:0] a, input logic [7:0] exp);
    logic ak;
    logic [7:0] q;
    i_host.access(1'b0, s, a, 8'h00, ak, q);
    chk(ak, 1);
    chk(q, exp);
  endtask : reg_rd
  task automatic tick(input logic two, input logic signed [15:0] v);
    @(posedge clk);
    if (two) begin t2 <= 1'b1; p2l <= v; end
    else begin t1 <= 1'b1; p1l <= v; end
    @(posedge clk);
    t1 <= 1'b0; t2 <= 1'b0;
    // valid stands the cycle after the capture edge; mix and decodes land one edge later
    @(negedge clk);
    vld_seen = dvld;
    @(negedge clk);
  endtask : tick
  // cycles between two rising pdm clock edges, bounded
  task automatic pdm_per(input int exp);
    int n, e;
    logic p;
    n = 0; e = 0; p = pclk;
    while (e < 2 && n < 60) begin
      @(negedge clk);
      n++;
      if (pclk && !p) begin e++; if (e == 1) n = 0; end
      p = pclk;
    end
    if (e < 2) begin fail_count++; print_verdict(); end
    else chk(n, exp);
  endtask : pdm_per
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(frame_sync_width, 1); chk(dac_l, 0);
    reg_rd(1'b0, 10'h011, 8'h00);
    reg_wr(1'b1, 8'h10, 8'h80);
    reg_rd(1'b0, 10'h010, 8'h80);
    reg_rd(1'b1, 10'h210, 8'h80);
    reg_rd(1'b1, 10'h2ff, 8'h00);
    reg_rd(1'b0, 10'h030, 8'h00);
    tick(1'b0, 16'sd100);
    chk(dac_l, 100); chk(vld_seen, 1); chk(dvld, 0);
    reg_wr(1'b0, 8'h10, 8'ha0);
    tick(1'b1, 16'sd20000);
    tick(1'b0, 16'sd30000);
    chk(dac_l, 32767);
    reg_wr(1'b0, 8'h17, 8'h7f); reg_wr(1'b0, 8'h18, 8'h3f); reg_wr(1'b0, 8'h1a, 8'h4f);
    reg_wr(1'b0, 8'h15, 8'h5f); reg_wr(1'b1, 8'h11, 8'h53);
    reg_wr(1'b0, 8'h08, 8'h06); reg_wr(1'b0, 8'h0a, 8'h0e);
    tick(1'b0, 16'sd30000);
    chk(dac_l, 20000); chk(vmut, 1); chk(smut, 0);
    chk(vc, 18); chk(va, -15); chk(adb, 6);
    chk(lroute, 1); chk(ldb, -6);
    chk(st_on, 1); chk(st_d, -60); chk(st_s, -65);
    chk(adc_iir, 5); chk(dac_iir, 3); chk(fir, 0);
    chk(slot, 4'he); chk(frame_sync_width, 16);
    reg_wr(1'b0, 8'h11, 8'h6e);
    tick(1'b0, 16'sd0);
    chk(adc_iir, 0); chk(dac_iir, 0);
    chk(p2dc, 1);
    reg_wr(1'b0, 8'h11, 8'h91);
    tick(1'b0, 16'sd0);
    chk(fir, 1); chk(adc_dc, 1); chk(dac_dc, 1); chk(vc, 0);
    chk(p2dc, 0);
    @(posedge clk);
    adl <= 16'sd1000;
    repeat (2) @(negedge clk);
    chk(sdt, 1000); chk(dac_l, 21000); chk(dac_r, 1000);
    reg_wr(1'b0, 8'h0d, 8'h06); reg_wr(1'b0, 8'h0f, 8'h0c); reg_wr(1'b0, 8'h0e, 8'h08);
    reg_wr(1'b0, 8'h16, 8'h4a); reg_wr(1'b0, 8'h19, 8'h21); reg_wr(1'b0, 8'h1b, 8'h45);
    reg_wr(1'b0, 8'h12, 8'h30); reg_wr(1'b0, 8'h13, 8'h22);
    tick(1'b1, 16'sd32767);
    chk(slot2, 4'hc); chk(fsw2, 16); chk(i4x, 1);
    chk(smut, 1); chk(sa, -10); chk(dac_l, 1000);
    chk(rdb, 3); chk(rldb, 14); chk(lroute, 0);
    tick(1'b0, 16'sd0);
    chk(rdb, 14);
    repeat (40) @(negedge clk);
    chk(pdat, 3);
    for (int c = 0; c < 3; c++) begin
      reg_wr(1'b0, 8'h12, {c[1:0], 6'h00});
      tick(1'b1, 16'sd0);
      pdm_per(AMF_DIV[c]);
    end
    reg_wr(1'b0, 8'h12, 8'hc0);
    tick(1'b1, 16'sd0);
    repeat (8) @(negedge clk);
    chk(pclk, 0);
    chk(pdat, 0);
    print_verdict();
  end
endmodule : audio_mix_filter_gain_pdm_bench
`default_nettype wire

// ==== shared/amf_pkg.sv ====
// Purpose: shared constants of the audio mix, filter, gain and pdm block
// Assumes: 8-bit control registers, one clock, samples in two's complement
// Notes: offsets are control-port (two-wire) addresses; four-wire adds a base
// Notes on behaviour
// - set slot delay bit delays slot one bit
// - high-rate bit picks 4x, else 8x interpolation
// - dac mixer bits add four path sources
// - filter mode: 0 iir voice, 1 fir audio
// - adc highpass: iir code, or dc block
// - dac highpass: iir code, or dc block
// - one bit enables path two dc block
// - iir codes 0..5 valid, 6..7 reserved
// - pdm clock is clk/8, /6, /4; 11 reserved
// - left and right pdm data enables
// - pdm mixer bits add four path sources
// - sidetone source: none, left, right, both
// - sidetone level off at zero, 2db steps
// - stereo and voice dac mute bits
// - voice coarse gain only in voice mode
// - adc fine level +3 down to -12db
// - line input mute disconnects headphone route
// - line input gain +24 down to -6db
// - four-wire address adds base, ff excluded
// - tdm bit enables slot delays
// - wide sync lasts sixteen bits in tdm
package amf_pkg;
  localparam logic [9:0] AMF_SPI_BASE = 10'h200;
  localparam logic [7:0] AMF_NO_SPI   = 8'hff;
  localparam logic [7:0] AMF_RESET    = 8'h00;
  localparam int         AMF_NREG     = 16;
  // register order: p1 mode, p1 tdm, p2 mode, p2 mode b, p2 tdm, dac mix,
  // filters, pdm cfg, pdm mix, sidetone, stereo dac, voice dac, adc l/r, line l/r
  localparam logic [7:0] AMF_OFS [AMF_NREG] = '{
    8'h08, 8'h0a, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
  localparam logic [7:0] AMF_MASK [AMF_NREG] = '{
    8'h06, 8'h0f, 8'h06, 8'h08, 8'h0f, 8'hff, 8'hff, 8'hf0,
    8'hff, 8'hdf, 8'h4f, 8'h7f, 8'h3f, 8'h3f, 8'h4f, 8'h4f};
  // which sample boundary moves a register into the active copy
  localparam logic [AMF_NREG-1:0] AMF_UPD_P1 = 16'hfbe3;
  localparam logic [AMF_NREG-1:0] AMF_UPD_P2 = 16'hc7bc;
  localparam int I_P1_MODE = 0;
  localparam int I_P1_TDM  = 1;
  localparam int I_P2_MODE = 2;
  localparam int I_P2_MODB = 3;
  localparam int I_P2_TDM  = 4;
  localparam int I_DAC_MIX = 5;
  localparam int I_FILT    = 6;
  localparam int I_PDM_CFG = 7;
  localparam int I_PDM_MIX = 8;
  localparam int I_SIDE    = 9;
  localparam int I_SDAC    = 10;
  localparam int I_VDAC    = 11;
  localparam int I_LADC    = 12;
  localparam int I_RADC    = 13;
  localparam int I_LLIN    = 14;
  localparam int I_RLIN    = 15;
  // field positions
  localparam int B_TDM     = 2;
  localparam int B_FSW     = 1;
  localparam int B_DHF     = 3;
  localparam int B_FMODE   = 7;
  localparam int B_DCB     = 3;
  localparam int B_PDM_L   = 5;
  localparam int B_PDM_R   = 4;
  localparam int B_MUTE    = 6;
  localparam logic [4:0] AMF_FS_WIDE   = 5'h10;
  localparam logic [4:0] AMF_FS_NARROW = 5'h01;
  localparam logic [2:0] AMF_IIR_LAST  = 3'h5;
  localparam logic [2:0] AMF_DCB_ON    = 3'h1;
  localparam logic [1:0] AMF_PDM_RSVD  = 2'h3;
  localparam logic [3:0] AMF_DIV [3]   = '{4'h8, 4'h6, 4'h4};
endpackage : amf_pkg

// ==== verilog/amf_core.sv ====
// Purpose: mixers, filter selection, gain decode and pdm output of the codec
// Assumes: register port strobes one cycle; sample ticks one cycle
// Notes: gains leave as signed db figures for the analog and filter stages
`timescale 1ns/10ps
`default_nettype none
module amf_core #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  input  wire logic                       i_reg_spi,
  input  wire logic [9:0]                 i_reg_addr,
  input  wire logic [7:0]                 i_reg_wdata,
  output logic      [7:0]                 o_reg_rdata,
  output logic                            o_reg_ack,
  input  wire logic                       i_p1_tick,
  input  wire logic                       i_p2_tick,
  input  wire logic signed [SAMPLE_W-1:0] i_p1_left,
  input  wire logic signed [SAMPLE_W-1:0] i_p1_right,
  input  wire logic signed [SAMPLE_W-1:0] i_p2_left,
  input  wire logic signed [SAMPLE_W-1:0] i_p2_right,
  input  wire logic signed [SAMPLE_W-1:0] i_adc_left,
  input  wire logic signed [SAMPLE_W-1:0] i_adc_right,
  output logic signed [SAMPLE_W-1:0]      o_dac_left,
  output logic signed [SAMPLE_W-1:0]      o_dac_right,
  output logic                            o_dac_valid,
  output logic signed [SAMPLE_W-1:0]      o_sidetone,
  output logic                            o_pdm_clk,
  output logic      [1:0]                 o_pdm_data_out,
  output logic      [3:0]                 o_p1_slot_delay,
  output logic      [3:0]                 o_p2_slot_delay,
  output logic      [4:0]                 o_p1_fs_width,
  output logic      [4:0]                 o_p2_fs_width,
  output logic                            o_interp_4x,
  output logic                            o_fir_mode,
  output logic      [2:0]                 o_adc_iir_code,
  output logic      [2:0]                 o_dac_iir_code,
  output logic                            o_adc_dc_block,
  output logic                            o_dac_dc_block,
  output logic                            o_p2_dc_block,
  output logic                            o_sidetone_on,
  output logic signed [7:0]               o_sidetone_db_diff,
  output logic signed [7:0]               o_sidetone_db_se,
  output logic                            o_stereo_dac_mute,
  output logic                            o_voice_dac_mute,
  output logic signed [7:0]               o_voice_coarse_db,
  output logic signed [7:0]               o_voice_atten_db,
  output logic signed [7:0]               o_stereo_atten_db,
  output logic signed [7:0]               o_adc_left_db,
  output logic signed [7:0]               o_adc_right_db,
  output logic      [1:0]                 o_line_in_route,
  output logic signed [7:0]               o_line_in_left_db,
  output logic signed [7:0]               o_line_in_right_db
);
  import amf_pkg::*;

  if (SAMPLE_W < 8 || SAMPLE_W > 24) begin : g_chk
    $error("amf_core: SAMPLE_W must be 8 to 24");
  end

  localparam int SW = SAMPLE_W + 3;
  localparam logic signed [SW-1:0] MAXV = SW'((1 <<< (SAMPLE_W - 1)) - 1);
  localparam logic signed [SW-1:0] MINV = -MAXV - SW'(1);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [7:0]          cfg [AMF_NREG];
  logic [7:0]          act [AMF_NREG];
  logic [AMF_NREG-1:0] hit;
  logic [7:0]          next_rdata;
  wire  logic [9:0]    loc_addr;
  wire  logic          in_space;

  assign loc_addr = 10'(i_reg_addr - (i_reg_spi ? AMF_SPI_BASE : 10'h000));
  // the highest two-wire address has no four-wire alias
  assign in_space = (loc_addr[9:8] == 2'b00)
                 && !(i_reg_spi && loc_addr[7:0] == AMF_NO_SPI);

  for (genvar k = 0; k < AMF_NREG; k++) begin : g_reg
    assign hit[k] = in_space && (loc_addr[7:0] == AMF_OFS[k]);
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        cfg[k] <= AMF_RESET;
      end else if (i_reg_wr && hit[k]) begin
        cfg[k] <= i_reg_wdata & AMF_MASK[k];
      end
    end
    // active copy moves only on the owning path's sample boundary, so a
    // half-written setting never splits a sample
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        act[k] <= AMF_RESET;
      end else if ((i_p1_tick && AMF_UPD_P1[k]) || (i_p2_tick && AMF_UPD_P2[k])) begin
        act[k] <= cfg[k];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    for (int k = 0; k < AMF_NREG; k++) begin
      if (hit[k]) begin
        next_rdata = cfg[k];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_ack   <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : 8'h00;
      o_reg_ack   <= i_reg_rd || i_reg_wr;
    end
  end

  // ----------------------------------------------------------------
  // active fields
  // ----------------------------------------------------------------
  wire logic       tdm1, tdm2, fsw1, fsw2, fmode;
  wire logic [2:0] adc_hp, dac_hp;
  wire logic [1:0] side_src;
  wire logic [4:0] side_lvl;
  wire logic       smute, vmute;

  assign tdm1     = act[I_P1_MODE][B_TDM];
  assign tdm2     = act[I_P2_MODE][B_TDM];
  assign fsw1     = act[I_P1_MODE][B_FSW];
  assign fsw2     = act[I_P2_MODE][B_FSW];
  assign fmode    = act[I_FILT][B_FMODE];
  assign adc_hp   = act[I_FILT][6:4];
  assign dac_hp   = act[I_FILT][2:0];
  assign side_src = act[I_SIDE][7:6];
  assign side_lvl = act[I_SIDE][4:0];
  assign smute    = act[I_SDAC][B_MUTE];
  assign vmute    = act[I_VDAC][B_MUTE];

  // ----------------------------------------------------------------
  // mixers
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] s1l, s1r, s2l, s2r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1l <= '0;
      s1r <= '0;
    end else if (i_p1_tick) begin
      s1l <= i_p1_left;
      s1r <= i_p1_right;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s2l <= '0;
      s2r <= '0;
    end else if (i_p2_tick) begin
      s2l <= i_p2_left;
      s2r <= i_p2_right;
    end
  end

  // clamp instead of wrap: a wrapped sum is a full-scale click
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [SW-1:0] v);
    if (v > MAXV) begin
      sat = MAXV[SAMPLE_W-1:0];
    end else if (v < MINV) begin
      sat = MINV[SAMPLE_W-1:0];
    end else begin
      sat = v[SAMPLE_W-1:0];
    end
  endfunction : sat

  // bit 3 p1 left, bit 2 p1 right, bit 1 p2 left, bit 0 p2 right; samples are
  // arguments so a continuous assignment re-evaluates whenever one of them moves
  function automatic logic signed [SW-1:0] mix4(input logic        [3:0]          sel,
                                                input logic                       m1,
                                                input logic                       m2,
                                                input logic signed [SAMPLE_W-1:0] a,
                                                input logic signed [SAMPLE_W-1:0] b,
                                                input logic signed [SAMPLE_W-1:0] c,
                                                input logic signed [SAMPLE_W-1:0] d);
    mix4 = '0;
    if (sel[3] && !m1) mix4 = mix4 + SW'(a);
    if (sel[2] && !m1) mix4 = mix4 + SW'(b);
    if (sel[1] && !m2) mix4 = mix4 + SW'(c);
    if (sel[0] && !m2) mix4 = mix4 + SW'(d);
  endfunction : mix4

  wire logic signed [SW-1:0]       side_sum, dac_l_sum, dac_r_sum;
  wire logic signed [SAMPLE_W-1:0] side_smp, next_dac_l, next_dac_r;

  assign side_sum = (side_src[1] ? SW'(i_adc_right) : SW'(0))
                  + (side_src[0] ? SW'(i_adc_left) : SW'(0));
  // level zero switches sidetone off altogether
  assign side_smp = (side_lvl == 5'h00) ? '0 : sat(side_sum);
  // voice dac mute gates path one, stereo dac mute gates path two
  assign dac_l_sum = mix4(act[I_DAC_MIX][7:4], vmute, smute, s1l, s1r, s2l, s2r)
                   + SW'(side_smp);
  assign dac_r_sum = mix4(act[I_DAC_MIX][3:0], vmute, smute, s1l, s1r, s2l, s2r)
                   + SW'(side_smp);
  assign next_dac_l = sat(dac_l_sum);
  assign next_dac_r = sat(dac_r_sum);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dac_left  <= '0;
      o_dac_right <= '0;
      o_dac_valid <= 1'b0;
      o_sidetone  <= '0;
    end else begin
      o_dac_left  <= next_dac_l;
      o_dac_right <= next_dac_r;
      o_dac_valid <= i_p1_tick || i_p2_tick;
      o_sidetone  <= side_smp;
    end
  end

  // ----------------------------------------------------------------
  // pdm output
  // ----------------------------------------------------------------
  wire  logic [1:0]                pdm_rate;
  wire  logic [3:0]                pdm_div;
  wire  logic                      pdm_flip;
  wire  logic                      pdm_rise;
  wire  logic signed [SAMPLE_W-1:0] pdm_l, pdm_r;
  logic [3:0]                      pdm_cnt;
  logic [SAMPLE_W-1:0]             acc_l, acc_r;
  wire  logic [SAMPLE_W:0]         nxt_l, nxt_r;

  assign pdm_rate = act[I_PDM_CFG][7:6];
  assign pdm_div  = (pdm_rate == AMF_PDM_RSVD) ? 4'h0 : AMF_DIV[pdm_rate];
  assign pdm_flip = (pdm_div != 4'h0) && (pdm_cnt == 4'((pdm_div >> 1) - 4'h1));
  assign pdm_rise = pdm_flip && !o_pdm_clk;
  assign pdm_l    = sat(mix4(act[I_PDM_MIX][7:4], 1'b0, 1'b0, s1l, s1r, s2l, s2r));
  assign pdm_r    = sat(mix4(act[I_PDM_MIX][3:0], 1'b0, 1'b0, s1l, s1r, s2l, s2r));
  // first-order modulator: carry out of the offset-binary accumulator
  assign nxt_l = {1'b0, acc_l} + {1'b0, ~pdm_l[SAMPLE_W-1], pdm_l[SAMPLE_W-2:0]};
  assign nxt_r = {1'b0, acc_r} + {1'b0, ~pdm_r[SAMPLE_W-1], pdm_r[SAMPLE_W-2:0]};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || pdm_div == 4'h0) begin
      pdm_cnt   <= 4'h0;
      o_pdm_clk <= 1'b0;
    end else if (pdm_flip) begin
      pdm_cnt   <= 4'h0;
      o_pdm_clk <= !o_pdm_clk;
    end else begin
      pdm_cnt   <= 4'(pdm_cnt + 4'h1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      acc_l          <= '0;
      acc_r          <= '0;
      o_pdm_data_out <= 2'b00;
    end else if (pdm_rise) begin
      acc_l             <= nxt_l[SAMPLE_W-1:0];
      acc_r             <= nxt_r[SAMPLE_W-1:0];
      o_pdm_data_out[1] <= act[I_PDM_CFG][B_PDM_L] && nxt_l[SAMPLE_W];
      o_pdm_data_out[0] <= act[I_PDM_CFG][B_PDM_R] && nxt_r[SAMPLE_W];
    end else begin
      o_pdm_data_out[1] <= o_pdm_data_out[1] && act[I_PDM_CFG][B_PDM_L];
      o_pdm_data_out[0] <= o_pdm_data_out[0] && act[I_PDM_CFG][B_PDM_R];
    end
  end

  // ----------------------------------------------------------------
  // framing, filter selection and gain decode
  // ----------------------------------------------------------------
  wire logic signed [7:0] ladc_db, radc_db;

  assign ladc_db = 8'(8'sd6 * $signed({6'h00, act[I_LADC][5:4]})) + 8'sd3
                 - $signed({4'h0, act[I_LADC][3:0]});
  assign radc_db = 8'(8'sd6 * $signed({6'h00, act[I_RADC][5:4]})) + 8'sd3
                 - $signed({4'h0, act[I_RADC][3:0]});

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_p1_slot_delay <= 4'h0;
      o_p2_slot_delay <= 4'h0;
      o_p1_fs_width   <= AMF_FS_NARROW;
      o_p2_fs_width   <= AMF_FS_NARROW;
      o_interp_4x     <= 1'b0;
    end else begin
      // slot n is bit n-1; delays exist only with tdm framing on
      o_p1_slot_delay <= tdm1 ? act[I_P1_TDM][3:0] : 4'h0;
      o_p2_slot_delay <= tdm2 ? act[I_P2_TDM][3:0] : 4'h0;
      o_p1_fs_width   <= (tdm1 && fsw1) ? AMF_FS_WIDE : AMF_FS_NARROW;
      o_p2_fs_width   <= (tdm2 && fsw2) ? AMF_FS_WIDE : AMF_FS_NARROW;
      o_interp_4x     <= act[I_P2_MODB][B_DHF];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_fir_mode     <= 1'b0;
      o_adc_iir_code <= 3'h0;
      o_dac_iir_code <= 3'h0;
      o_adc_dc_block <= 1'b0;
      o_dac_dc_block <= 1'b0;
      o_p2_dc_block  <= 1'b0;
    end else begin
      o_fir_mode     <= fmode;
      // reserved iir codes are treated as no highpass
      o_adc_iir_code <= (!fmode && adc_hp <= AMF_IIR_LAST) ? adc_hp : 3'h0;
      o_dac_iir_code <= (!fmode && dac_hp <= AMF_IIR_LAST) ? dac_hp : 3'h0;
      o_adc_dc_block <= fmode && adc_hp == AMF_DCB_ON;
      o_dac_dc_block <= fmode && dac_hp == AMF_DCB_ON;
      o_p2_dc_block  <= act[I_FILT][B_DCB];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sidetone_on      <= 1'b0;
      o_sidetone_db_diff <= 8'sh00;
      o_sidetone_db_se   <= 8'sh00;
      o_stereo_dac_mute  <= 1'b0;
      o_voice_dac_mute   <= 1'b0;
      o_voice_coarse_db  <= 8'sh00;
      o_voice_atten_db   <= 8'sh00;
      o_stereo_atten_db  <= 8'sh00;
    end else begin
      o_sidetone_on      <= side_lvl != 5'h00 && side_src != 2'b00;
      o_sidetone_db_diff <= (side_lvl == 5'h00) ? 8'sh00
                          : 8'(8'sd2 - 8'sd2 * $signed({3'h0, side_lvl}));
      o_sidetone_db_se   <= (side_lvl == 5'h00) ? 8'sh00
                          : 8'(-8'sd3 - 8'sd2 * $signed({3'h0, side_lvl}));
      o_stereo_dac_mute  <= smute;
      o_voice_dac_mute   <= vmute;
      o_voice_coarse_db  <= fmode ? 8'sh00
                          : 8'(8'sd6 * $signed({6'h00, act[I_VDAC][5:4]}));
      o_voice_atten_db   <= -$signed({4'h0, act[I_VDAC][3:0]});
      o_stereo_atten_db  <= -$signed({4'h0, act[I_SDAC][3:0]});
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_adc_left_db      <= 8'sh00;
      o_adc_right_db     <= 8'sh00;
      o_line_in_route    <= 2'b00;
      o_line_in_left_db  <= 8'sh00;
      o_line_in_right_db <= 8'sh00;
    end else begin
      o_adc_left_db      <= ladc_db;
      o_adc_right_db     <= radc_db;
      o_line_in_route    <= {!act[I_LLIN][B_MUTE], !act[I_RLIN][B_MUTE]};
      o_line_in_left_db  <= 8'(8'sd24 - 8'sd2 * $signed({4'h0, act[I_LLIN][3:0]}));
      o_line_in_right_db <= 8'(8'sd24 - 8'sd2 * $signed({4'h0, act[I_RLIN][3:0]}));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_ACK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("register access not answered");
  AST_SPI_FF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_reg_rd && i_reg_spi && i_reg_addr == 10'h2ff) |=> o_reg_rdata == 8'h00)
    else $error("register ff answered over four-wire port");
  AST_SLOT_TDM: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !tdm1 |=> o_p1_slot_delay == 4'h0)
    else $error("slot delay outside tdm framing");
  AST_FS_WIDE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tdm2 && fsw2) |=> o_p2_fs_width == 5'h10)
    else $error("wide frame sync not sixteen bits");
  AST_INTERP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_interp_4x) |-> $past(i_p2_tick, 2))
    else $error("interpolation changed off a sample boundary");
  AST_PDM_RSVD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (pdm_rate == AMF_PDM_RSVD) [*2] |-> !o_pdm_clk)
    else $error("pdm clock runs at reserved rate");
  AST_PDM_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !act[I_PDM_CFG][B_PDM_L] |=> !o_pdm_data_out[1])
    else $error("left pdm data while disabled");
  AST_DAC_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (act[I_DAC_MIX] == 8'h00 && side_lvl == 5'h00) |=> o_dac_left == '0)
    else $error("dac output with no source selected");
  AST_VGAIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    fmode |=> o_voice_coarse_db == 8'sh00)
    else $error("voice dac gain in audio mode");
endmodule : amf_core
`default_nettype wire
